// File: rcr_pkg.sv
// Constants for the reset-cause register block.
// Assumes a 25 MHz system clock and an 8-bit special-function bus.
package rcr_pkg;

  // ***************************************************************
  // Register location
  // ***************************************************************
  localparam logic [7:0] RCR_SFR_PAGE = 8'h00;
  localparam logic [7:0] RCR_SFR_ADDR = 8'hEF;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int RCR_BIT_RTC   = 7;
  localparam int RCR_BIT_FLASH = 6;
  localparam int RCR_BIT_CMP   = 5;
  localparam int RCR_BIT_SOFT  = 4;
  localparam int RCR_BIT_WDOG  = 3;
  localparam int RCR_BIT_CLK   = 2;
  localparam int RCR_BIT_PWR   = 1;
  localparam int RCR_BIT_PIN   = 0;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RCR_CAUSE_POR  = 8'h02;
  localparam logic [7:0] RCR_BYTE_ZERO  = 8'h00;
  localparam logic       RCR_EN_RESET   = 1'b0;
  localparam logic       RCR_SUP_RESET  = 1'b0;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int RCR_CLK_PERIOD_NS  = 40;
  localparam int RCR_MCD_TIMEOUT_NS = 100000;
  localparam int RCR_MCD_CYCLES_INT =
    (RCR_MCD_TIMEOUT_NS + RCR_CLK_PERIOD_NS - 1) / RCR_CLK_PERIOD_NS;
  localparam int RCR_MCD_CW = 12;
  localparam logic [RCR_MCD_CW-1:0] RCR_MCD_CYCLES =
    RCR_MCD_CYCLES_INT[RCR_MCD_CW-1:0];
  localparam logic [RCR_MCD_CW-1:0] RCR_MCD_ZERO = 12'h000;
  localparam logic [RCR_MCD_CW-1:0] RCR_MCD_ONE  = 12'h001;

  localparam int RCR_HOLD_CW = 5;
  localparam logic [RCR_HOLD_CW-1:0] RCR_HOLD_LAST = 5'h0F;
  localparam logic [RCR_HOLD_CW-1:0] RCR_HOLD_ZERO = 5'h00;
  localparam logic [RCR_HOLD_CW-1:0] RCR_HOLD_ONE  = 5'h01;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic {RCR_RUN, RCR_HOLD} rcr_state_type;

endpackage

// File: rcr_mcd_if.sv
// Link between the cause register and the clock-loss detector.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rcr_mcd_if;
  logic enable;
  logic clear;
  logic timeout;

  modport ctrl (output enable, output clear, input timeout);
  modport det  (input enable, input clear, output timeout);
endinterface

// File: rcr_clock_loss.sv
// Clock-loss detector: times a watched clock that stops at one level.
// Assumes mon_clk_i is sampled on clk_i as a synchronous level.
`timescale 1ns/1ps
module rcr_clock_loss
  import rcr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic mon_clk_i,
  rcr_mcd_if.det    mcd
);

  // ***************************************************************
  // Quiet-time counter
  // ***************************************************************
  logic                  level_q;
  logic                  level_d;
  logic [RCR_MCD_CW-1:0] count_q;
  logic [RCR_MCD_CW-1:0] count_d;
  logic                  trip_q;
  logic                  trip_d;

  always_comb
  begin
    level_d = mon_clk_i;
    count_d = count_q;
    trip_d  = trip_q;
    if (!mcd.enable || mcd.clear || (mon_clk_i != level_q))
    begin
      count_d = RCR_MCD_ZERO;
      trip_d  = 1'b0;
    end
    else if (count_q == RCR_MCD_CYCLES)
    begin
      trip_d = 1'b1;
    end
    else
    begin
      count_d = count_q + RCR_MCD_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      level_q <= 1'b0;
      count_q <= RCR_MCD_ZERO;
      trip_q  <= 1'b0;
    end
    else
    begin
      level_q <= level_d;
      count_q <= count_d;
      trip_q  <= trip_d;
    end
  end

  assign mcd.timeout = trip_q;

endmodule

// File: rcr_top.sv
// Reset-cause register with its reset sources and reset sequencer.
// Assumes arst_n_i is the power-on reset and all inputs are synchronous.
`timescale 1ns/1ps
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Special-function bus
  input  wire logic [7:0] sfr_page_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Reset sources
  input  wire logic       pin_reset_n_i,
  input  wire logic       rtc_event_i,
  input  wire logic       flash_fault_i,
  input  wire logic       comparator_trip_i,
  input  wire logic       watchdog_overflow_i,
  input  wire logic       supply_low_i,
  input  wire logic       mon_clk_i,
  input  wire logic       low_power_i,
  // Reset and enable outputs
  output logic            system_reset_o,
  output logic            rtc_reset_en_o,
  output logic            comparator_reset_en_o,
  output logic            clock_loss_en_o,
  output logic            supply_reset_en_o
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic hit;
  logic wr_hit;
  logic rd_hit;

  assign hit    = (sfr_page_i == RCR_SFR_PAGE)
               && (sfr_addr_i == RCR_SFR_ADDR);
  assign wr_hit = hit && sfr_wr_i;
  assign rd_hit = hit && sfr_rd_i;

  // ***************************************************************
  // Write fields
  // ***************************************************************
  logic wr_rtc_en;
  logic wr_cmp_en;
  logic wr_mcd_en;
  logic wr_sup_en;
  logic wr_soft;

  assign wr_rtc_en = sfr_wdata_i[RCR_BIT_RTC];
  assign wr_cmp_en = sfr_wdata_i[RCR_BIT_CMP];
  assign wr_mcd_en = sfr_wdata_i[RCR_BIT_CLK];
  assign wr_sup_en = sfr_wdata_i[RCR_BIT_PWR];
  assign wr_soft   = wr_hit && sfr_wdata_i[RCR_BIT_SOFT];

  // ***************************************************************
  // Clock-loss detector
  // ***************************************************************
  rcr_mcd_if mcd ();

  rcr_clock_loss u_clock_loss
  (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .mon_clk_i (mon_clk_i),
    .mcd       (mcd.det)
  );

  // ***************************************************************
  // State
  // ***************************************************************
  rcr_state_type          state_q;
  rcr_state_type          state_d;
  logic [RCR_HOLD_CW-1:0] hold_q;
  logic [RCR_HOLD_CW-1:0] hold_d;
  logic [7:0]             cause_q;
  logic [7:0]             cause_d;
  logic                   rtc_en_q;
  logic                   rtc_en_d;
  logic                   cmp_en_q;
  logic                   cmp_en_d;
  logic                   mcd_en_q;
  logic                   mcd_en_d;
  logic                   sup_en_q;
  logic                   sup_en_d;
  logic [7:0]             rdata_q;
  logic [7:0]             rdata_d;
  logic [7:0]             event_vec;
  logic                   mcd_live;
  logic                   reset_start;
  logic                   en_write;

  // Detector gated off while the device is in a low-power mode
  assign mcd_live = mcd_en_q && !low_power_i;

  // ***************************************************************
  // Reset sources
  // ***************************************************************
  always_comb
  begin
    event_vec = RCR_BYTE_ZERO;
    event_vec[RCR_BIT_RTC]   = rtc_event_i && rtc_en_q;
    event_vec[RCR_BIT_FLASH] = flash_fault_i;
    event_vec[RCR_BIT_CMP]   = comparator_trip_i && cmp_en_q;
    event_vec[RCR_BIT_SOFT]  = wr_soft;
    event_vec[RCR_BIT_WDOG]  = watchdog_overflow_i;
    event_vec[RCR_BIT_CLK]   = mcd.timeout && mcd_live;
    // Enabling while the supply is unstable may reset at once
    event_vec[RCR_BIT_PWR]   = supply_low_i && sup_en_q;
    event_vec[RCR_BIT_PIN]   = !pin_reset_n_i;
  end

  // ***************************************************************
  // Reset sequencer
  // ***************************************************************

  // Any source event while running starts a reset
  assign reset_start = (state_q == RCR_RUN)
                    && (event_vec != RCR_BYTE_ZERO);

  always_comb
  begin
    state_d = state_q;
    hold_d  = hold_q;
    unique case (state_q)
      RCR_RUN:
      begin
        if (reset_start)
        begin
          state_d = RCR_HOLD;
          hold_d  = RCR_HOLD_LAST;
        end
      end
      RCR_HOLD:
      begin
        if (!pin_reset_n_i)
        begin
          // Pin held low keeps the system in reset
          hold_d = RCR_HOLD_LAST;
        end
        else if (hold_q == RCR_HOLD_ZERO)
        begin
          state_d = RCR_RUN;
        end
        else
        begin
          hold_d = hold_q - RCR_HOLD_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= RCR_RUN;
      hold_q  <= RCR_HOLD_ZERO;
    end
    else
    begin
      state_q <= state_d;
      hold_q  <= hold_d;
    end
  end

  // ***************************************************************
  // Cause flags
  // ***************************************************************
  always_comb
  begin
    cause_d = cause_q;
    if (reset_start)
    begin
      // Only sources of this reset are flagged
      cause_d = event_vec;
      if (event_vec[RCR_BIT_PWR])
      begin
        cause_d = RCR_CAUSE_POR;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cause_q <= RCR_CAUSE_POR;
    end
    else
    begin
      cause_q <= cause_d;
    end
  end

  // ***************************************************************
  // Reset-source enables
  // ***************************************************************
  // Writes count only while running and free of source events
  assign en_write = (state_q == RCR_RUN) && wr_hit
                 && (event_vec == RCR_BYTE_ZERO);

  always_comb
  begin
    rtc_en_d = rtc_en_q;
    cmp_en_d = cmp_en_q;
    mcd_en_d = mcd_en_q;
    sup_en_d = sup_en_q;
    if (reset_start)
    begin
      // Supply enable survives a reset, the others start off
      rtc_en_d = RCR_EN_RESET;
      cmp_en_d = RCR_EN_RESET;
      mcd_en_d = RCR_EN_RESET;
    end
    else if (en_write)
    begin
      // Written-back flags 7, 5, 2, 1 set enables and 4 starts a reset; read-only bits dropped
      rtc_en_d = wr_rtc_en;
      cmp_en_d = wr_cmp_en;
      mcd_en_d = wr_mcd_en;
      sup_en_d = wr_sup_en;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rtc_en_q <= RCR_EN_RESET;
      cmp_en_q <= RCR_EN_RESET;
      mcd_en_q <= RCR_EN_RESET;
      sup_en_q <= RCR_SUP_RESET;
    end
    else
    begin
      rtc_en_q <= rtc_en_d;
      cmp_en_q <= cmp_en_d;
      mcd_en_q <= mcd_en_d;
      sup_en_q <= sup_en_d;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  // Read data from the cause flags, zero when not addressed
  always_comb
  begin
    rdata_d = RCR_BYTE_ZERO;
    if (rd_hit)
    begin
      rdata_d = cause_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= RCR_BYTE_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign mcd.enable  = mcd_live;
  assign mcd.clear   = (state_q == RCR_HOLD);

  assign sfr_rdata_o           = rdata_q;
  assign system_reset_o        = (state_q == RCR_HOLD);
  assign rtc_reset_en_o        = rtc_en_q;
  assign comparator_reset_en_o = cmp_en_q;
  assign clock_loss_en_o       = mcd_live;
  assign supply_reset_en_o     = sup_en_q;

endmodule

// File: rcr_top_monitor.sv
// Port checker for the reset-cause register.
// Assumes it is bound onto every rcr_top instance.
`timescale 1ns/1ps
module rcr_monitor
(
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       pin_reset_n_i,
  input wire logic       rtc_event_i,
  input wire logic       flash_fault_i,
  input wire logic       comparator_trip_i,
  input wire logic       watchdog_overflow_i,
  input wire logic       supply_low_i,
  input wire logic       low_power_i,
  input wire logic       system_reset_o,
  input wire logic       rtc_reset_en_o,
  input wire logic       comparator_reset_en_o,
  input wire logic       clock_loss_en_o,
  input wire logic       supply_reset_en_o
);
  // ****************
  // Port relations
  // ****************
  wire hit = sfr_page_i == 8'h00 && sfr_addr_i == 8'hEF;
  wire wr_hit = hit && sfr_wr_i;
  wire quiet = !system_reset_o && pin_reset_n_i && !rtc_event_i
    && !flash_fault_i && !comparator_trip_i && !watchdog_overflow_i
    && !supply_low_i && !sfr_wdata_i[4];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_hold8;
    system_reset_o [*8];
  endsequence

  a_read_idle: assert property (
    !$past(hit && sfr_rd_i) |-> sfr_rdata_o == 8'h00)
    else $error("Read data not zero without a read");
  a_wdog_reset: assert property (
    watchdog_overflow_i && !system_reset_o |=> system_reset_o)
    else $error("Watchdog overflow gave no reset");
  a_soft_force: assert property (
    wr_hit && sfr_wdata_i[4] && !system_reset_o |=> system_reset_o)
    else $error("Soft reset write gave no reset");
  a_pin_reset: assert property (
    !pin_reset_n_i |=> system_reset_o)
    else $error("Reset pin gave no reset");
  a_cmp_reset: assert property (
    comparator_trip_i && comparator_reset_en_o && !system_reset_o
    |=> system_reset_o)
    else $error("Enabled comparator gave no reset");
  a_en_write: assert property (
    wr_hit && quiet |=> rtc_reset_en_o == $past(sfr_wdata_i[7])
    && comparator_reset_en_o == $past(sfr_wdata_i[5])
    && supply_reset_en_o == $past(sfr_wdata_i[1]))
    else $error("Enable bits do not follow write");
  a_clk_gate: assert property (
    clock_loss_en_o |-> !low_power_i)
    else $error("Clock-loss reset armed in low power");
  a_reset_hold: assert property (
    $rose(system_reset_o) |-> s_hold8 ##1 s_hold8)
    else $error("System reset shorter than 16 cycles");
  a_supply_kept: assert property (
    $rose(system_reset_o) && $past(supply_reset_en_o)
    |-> supply_reset_en_o)
    else $error("Supply enable lost on reset");
endmodule

bind rcr_top rcr_monitor u_mon (.clk_i, .arst_n_i, .sfr_page_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
  .pin_reset_n_i, .rtc_event_i, .flash_fault_i, .comparator_trip_i,
  .watchdog_overflow_i, .supply_low_i, .low_power_i, .system_reset_o,
  .rtc_reset_en_o, .comparator_reset_en_o, .clock_loss_en_o,
  .supply_reset_en_o);

// File: rcr_tb.sv
// Self-checking bench for the reset-cause register.
// Assumes rcr_top and its bound monitor are compiled alongside.
`timescale 1ns/1ps
module testbench;
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] page = 8'h00;
  logic [7:0] addr = 8'hEF;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  logic       pin_n = 1'b1;
  logic [4:0] src = 5'h00;
  logic       mon = 1'b0;
  logic       mstop = 1'b0;
  logic       lp = 1'b0;
  logic       sys, e_rtc, e_cmp, e_clk, e_sup;
  int         num_errors = 0;
  int         n_tests = 0;
  logic [7:0] ex [5] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h80};

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (!mstop) mon <= ~mon;

  rcr_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_page_i(page),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdat), .sfr_rdata_o(rdat), .pin_reset_n_i(pin_n),
    .rtc_event_i(src[4]), .flash_fault_i(src[3]),
    .comparator_trip_i(src[2]), .watchdog_overflow_i(src[1]),
    .supply_low_i(src[0]), .mon_clk_i(mon), .low_power_i(lp),
    .system_reset_o(sys), .rtc_reset_en_o(e_rtc),
    .comparator_reset_en_o(e_cmp), .clock_loss_en_o(e_clk),
    .supply_reset_en_o(e_sup));

  // ****************
  // Shared tasks
  // ****************
  task automatic step;
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrb(input logic [7:0] d);
    wr = 1'b1;
    wdat = d;
    step;
    wr = 1'b0;
  endtask
  task automatic rdb(input logic [7:0] e);
    rd = 1'b1;
    step;
    rd = 1'b0;
    chk(rdat, e);
  endtask
  // Counts reset cycles; zero means length not judged
  task automatic hold(input logic [7:0] e);
    int n;
    int w;
    n = 0;
    w = 0;
    while (sys !== 1'b1 && w < 9)
    begin
      w++;
      step;
    end
    while (sys === 1'b1 && n < 99)
    begin
      n++;
      step;
    end
    if (e != 8'h00) chk(8'(n), e);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_power_up;
    rdb(8'h02);
    page = 8'h01;
    rdb(8'h00);
    page = 8'h00;
    addr = 8'hEE;
    rdb(8'h00);
    wrb(8'h10);
    chk({7'h00, sys}, 8'h00);
    addr = 8'hEF;
  endtask
  task automatic t_enables;
    wrb(8'hA6);
    chk({4'h0, e_rtc, e_cmp, e_clk, e_sup}, 8'h0F);
    lp = 1'b1;
    step;
    chk({7'h00, e_clk}, 8'h00);
    lp = 1'b0;
    step;
    chk({7'h00, e_clk}, 8'h01);
    wrb(8'h49);
    chk({4'h0, e_rtc, e_cmp, e_clk, e_sup}, 8'h00);
    rdb(8'h02);
  endtask
  task automatic t_cause(input int k);
    wrb(8'hA2);
    src = 5'h01 << k;
    step;
    src = 5'h00;
    hold(8'h10);
    rdb(ex[k]);
  endtask
  task automatic t_gated;
    src = 5'h14;
    repeat (4) step;
    src = 5'h00;
    chk({7'h00, sys}, 8'h00);
  endtask
  task automatic t_rmw;
    t_cause(1);
    wrb(ex[1] | 8'h20);
    chk({6'h00, sys, e_cmp}, 8'h01);
    rdb(8'h08);
  endtask
  task automatic t_soft;
    wrb(8'h10);
    hold(8'h10);
    rdb(8'h10);
  endtask
  task automatic t_pin;
    pin_n = 1'b0;
    repeat (3) step;
    pin_n = 1'b1;
    hold(8'h10);
    rdb(8'h01);
  endtask
  task automatic t_clock_loss;
    int w;
    wrb(8'h04);
    mstop = 1'b1;
    w = 0;
    while (sys !== 1'b1 && w < 3000)
    begin
      w++;
      step;
    end
    mstop = 1'b0;
    chk({7'h00, w >= 2499 && w <= 2506}, 8'h01);
    hold(8'h10);
    rdb(8'h04);
  endtask
  task automatic t_power_cycle;
    wrb(8'hA6);
    arst_n_i = 1'b0;
    step;
    chk({3'h0, sys, e_rtc, e_cmp, e_clk, e_sup}, 8'h00);
    arst_n_i = 1'b1;
    step;
    rdb(8'h02);
  endtask

  initial
  begin
    #1000000;
    num_errors++;
    report_and_stop;
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    #2;
    arst_n_i = 1'b1;
    step;
    t_power_up;
    t_enables;
    for (int k = 0; k < 5; k++) t_cause(k);
    t_gated;
    t_rmw;
    t_soft;
    t_pin;
    t_clock_loss;
    t_power_cycle;
    report_and_stop;
  end
endmodule
